// File: rtl/drive_pkg.sv
package drive_pkg;

  // Clock rate and ramp tick
  localparam int CLK_MHZ        = 250;
  localparam int TICK_US        = 1000;
  localparam int TICK_CYCLES    = TICK_US * CLK_MHZ;
  // Accel/decel times are counted in units of 0.1 s
  localparam int TIME_UNIT_US   = 100000;
  localparam int TICKS_PER_UNIT = TIME_UNIT_US / TICK_US;

  localparam int FREQ_W     = 16;  // 0.01 Hz per lsb
  localparam int TIME_W     = 16;  // 0.1 s per lsb
  localparam int FUNC_W     = 5;
  localparam int NUM_INPUTS = 4;
  localparam int FRAC_W     = 16;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFS   = 8'h00;
  localparam logic [7:0] KEY_OFFS    = 8'h04;
  localparam logic [7:0] FUNC_OFFS   = 8'h08;
  localparam logic [7:0] MAIN_OFFS   = 8'h0C;
  localparam logic [7:0] STEP1_OFFS  = 8'h10;
  localparam logic [7:0] STEP2_OFFS  = 8'h14;
  localparam logic [7:0] STEP3_OFFS  = 8'h18;
  localparam logic [7:0] TOP_OFFS    = 8'h1C;
  localparam logic [7:0] MINST_OFFS  = 8'h20;
  localparam logic [7:0] ACC_OFFS    = 8'h24;
  localparam logic [7:0] DEC_OFFS    = 8'h28;
  localparam logic [7:0] STATUS_OFFS = 8'h2C;
  localparam logic [7:0] TARGET_OFFS = 8'h30;

  // Control, key, function and status register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_DIR_BIT  = 2;
  localparam int CTRL_INH_LSB  = 3;
  localparam int CTRL_PWR_BIT  = 5;
  localparam int CTRL_FLT_BIT  = 6;
  localparam int KEY_RUN_BIT   = 0;
  localparam int KEY_STOP_BIT  = 1;
  localparam int FUNC_STRIDE   = 8;
  localparam int ST_RUN_BIT    = 16;
  localparam int ST_REV_BIT    = 17;
  localparam int ST_AT_BIT     = 18;
  localparam int ST_FLT_BIT    = 19;

  // Reset values and write limits
  localparam logic [FREQ_W-1:0] MAIN_RST  = 16'h0000;
  localparam logic [FREQ_W-1:0] STEP1_RST = 16'h03E8;  // 10.00 Hz
  localparam logic [FREQ_W-1:0] STEP2_RST = 16'h07D0;  // 20.00 Hz
  localparam logic [FREQ_W-1:0] STEP3_RST = 16'h0BB8;  // 30.00 Hz
  localparam logic [FREQ_W-1:0] FREQ_LIM  = 16'h4E20;  // 200.00 Hz
  localparam logic [FREQ_W-1:0] TOP_RST   = 16'h1770;  // 60.00 Hz
  localparam logic [FREQ_W-1:0] MINST_RST = 16'h0032;  // 0.50 Hz
  localparam logic [TIME_W-1:0] ACC_RST   = 16'h0032;  // 5.0 s
  localparam logic [TIME_W-1:0] DEC_RST   = 16'h0064;  // 10.0 s
  localparam logic [TIME_W-1:0] TIME_LIM  = 16'hEA60;  // 6000.0 s

  // Input function codes
  localparam logic [FUNC_W-1:0] FN_FWD     = 5'h00;
  localparam logic [FUNC_W-1:0] FN_REV     = 5'h01;
  localparam logic [FUNC_W-1:0] FN_STEP_LO = 5'h05;
  localparam logic [FUNC_W-1:0] FN_STEP_HI = 5'h06;
  localparam logic [FUNC_W-1:0] FUNC_RST0  = 5'h00;
  localparam logic [FUNC_W-1:0] FUNC_RST1  = 5'h01;
  localparam logic [FUNC_W-1:0] FUNC_RST2  = 5'h02;
  localparam logic [FUNC_W-1:0] FUNC_RST3  = 5'h03;

  localparam logic [1:0] INH_FWD  = 2'h1;
  localparam logic [1:0] INH_REV  = 2'h2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_KEYPAD   = 2'h0,
    MODE_FWD_REV  = 2'h1,
    MODE_RUN_DIR  = 2'h2,
    MODE_RESERVED = 2'h3
  } drive_mode_type;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_BUSY = 2'b10
  } div_state_type;

  typedef logic [NUM_INPUTS-1:0][FUNC_W-1:0] func_arr_type;

  typedef struct packed {
    drive_mode_type    drive_mode;
    logic              rotation_dir_select;  // 0 = F (CW), 1 = r (CCW)
    logic [1:0]        direction_inhibit;
    logic              powerup_autostart;
    logic              fault_clear_autostart;
    func_arr_type      input_function;
    logic [FREQ_W-1:0] main_freq;
    logic [FREQ_W-1:0] step_freq_one;
    logic [FREQ_W-1:0] step_freq_two;
    logic [FREQ_W-1:0] step_freq_three;
    logic [FREQ_W-1:0] top_frequency;
    logic [FREQ_W-1:0] min_start_frequency;
    logic [TIME_W-1:0] acc_time;
    logic [TIME_W-1:0] dec_time;
  } cfg_type;

endpackage

// File: rtl/freq_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module freq_ramp
  import drive_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              nrst_i,
  input  wire logic              tick_i,
  input  wire logic [FREQ_W-1:0] target_i,
  input  wire logic [FREQ_W-1:0] top_i,
  input  wire logic [TIME_W-1:0] acc_time_i,
  input  wire logic [TIME_W-1:0] dec_time_i,
  output logic      [FREQ_W-1:0] freq_o,
  output logic                   at_target_o
);

  localparam int ACC_W = FREQ_W + FRAC_W;
  localparam logic [5:0] DIV_STEPS = 6'(ACC_W);

  div_state_type    div_state_r;
  logic [ACC_W:0]   rem_r;
  logic [ACC_W-1:0] quo_r;
  logic [ACC_W-1:0] dvs_r;
  logic [5:0]       cnt_r;
  logic [ACC_W-1:0] inc_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] tgt;
  logic [TIME_W-1:0] time_sel;
  logic [ACC_W:0]   rem_sh;

  assign tgt      = {target_i, {FRAC_W{1'b0}}};
  assign time_sel = (tgt > acc_r) ? acc_time_i : dec_time_i;
  assign rem_sh   = {rem_r[ACC_W-1:0], quo_r[ACC_W-1]};

  // slope from top/time
  // Divider runs continuously so a changed setting takes effect within a few ticks
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      div_state_r <= DIV_IDLE;
      rem_r       <= '0;
      quo_r       <= '0;
      dvs_r       <= '0;
      cnt_r       <= '0;
      inc_r       <= '0;
    end else begin
      unique case (div_state_r)
        DIV_IDLE: begin
          rem_r       <= '0;
          quo_r       <= {top_i, {FRAC_W{1'b0}}};
          dvs_r       <= ACC_W'(time_sel) * ACC_W'(TICKS_PER_UNIT);
          cnt_r       <= '0;
          div_state_r <= DIV_BUSY;
        end
        DIV_BUSY: begin
          if (rem_sh >= {1'b0, dvs_r}) begin
            rem_r <= rem_sh - {1'b0, dvs_r};
            quo_r <= {quo_r[ACC_W-2:0], 1'b1};
          end else begin
            rem_r <= rem_sh;
            quo_r <= {quo_r[ACC_W-2:0], 1'b0};
          end
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == DIV_STEPS - 6'h01) begin
            div_state_r <= DIV_IDLE;
          end
        end
      endcase
      // Zero time: divider yields all ones, giving a one-tick jump
      if (div_state_r == DIV_BUSY && cnt_r == DIV_STEPS) begin
        inc_r <= quo_r;
      end else if (div_state_r == DIV_IDLE && cnt_r == DIV_STEPS) begin
        inc_r <= quo_r;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      acc_r <= '0;
    end else if (tick_i) begin
      if (acc_r < tgt) begin
        acc_r <= (tgt - acc_r <= inc_r) ? tgt : acc_r + inc_r;
      end else if (acc_r > tgt) begin
        acc_r <= (acc_r - tgt <= inc_r) ? tgt : acc_r - inc_r;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      freq_o      <= '0;
      at_target_o <= 1'b1;
    end else begin
      freq_o      <= acc_r[ACC_W-1:FRAC_W];
      at_target_o <= (acc_r == tgt);
    end
  end

endmodule
`default_nettype wire

// File: rtl/drive_run_command_ramp.sv
`timescale 1ns/1ns
`default_nettype none
module drive_run_command_ramp
  import drive_pkg::*;
#(
  parameter int TICK_CNT = TICK_CYCLES
) (
  input  wire logic                  mclk_i,
  input  wire logic                  nrst_i,
  input  wire logic [NUM_INPUTS-1:0] term_i,
  input  wire logic                  fault_i,
  input  wire logic [7:0]            awaddr_i,
  input  wire logic                  awvalid_i,
  output logic                       awready_o,
  input  wire logic [31:0]           wdata_i,
  input  wire logic [3:0]            wstrb_i,
  input  wire logic                  wvalid_i,
  output logic                       wready_o,
  output logic [1:0]                 bresp_o,
  output logic                       bvalid_o,
  input  wire logic                  bready_i,
  input  wire logic [7:0]            araddr_i,
  input  wire logic                  arvalid_i,
  output logic                       arready_o,
  output logic [31:0]                rdata_o,
  output logic [1:0]                 rresp_o,
  output logic                       rvalid_o,
  input  wire logic                  rready_i,
  output logic [FREQ_W-1:0]          out_freq_o,
  output logic                       running_o,
  output logic                       reverse_o
);

  cfg_type               cfg_r;
  logic [NUM_INPUTS-1:0] term_meta_r;
  logic [NUM_INPUTS-1:0] term_r;
  logic                  fault_meta_r;
  logic                  fault_r;
  logic [1:0]            settle_r;
  logic [31:0]           tick_cnt_r;
  logic                  tick_r;
  logic [7:0]            aw_addr_r;
  logic                  aw_got_r;
  logic [31:0]           w_data_r;
  logic [3:0]            w_strb_r;
  logic                  w_got_r;
  logic                  key_run_r;
  logic                  key_stop_r;
  logic                  kp_run_r;
  logic                  hold_pwr_r;
  logic                  hold_flt_r;
  logic                  dir_r;
  logic                  run_ok;
  logic                  cmd_dir;
  logic                  term_cmd;
  logic [FREQ_W-1:0]     ref_freq;
  logic [FREQ_W-1:0]     target;
  logic [FREQ_W-1:0]     ramp_freq;
  logic                  at_target;
  logic [31:0]           rdata_nxt;
  logic                  rd_hit;
  logic                  do_write;

  function automatic logic any_func(input func_arr_type f, input logic [NUM_INPUTS-1:0] lvl,
                                    input logic [FUNC_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      hit = hit | (lvl[i] & (f[i] == code));
    end
    return hit;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Saturate on the whole word so an oversized write cannot wrap to a small value
  function automatic logic [FREQ_W-1:0] lim_freq(input logic [31:0] v);
    return (v > 32'(FREQ_LIM)) ? FREQ_LIM : v[FREQ_W-1:0];
  endfunction

  function automatic logic [TIME_W-1:0] lim_time(input logic [31:0] v);
    return (v > 32'(TIME_LIM)) ? TIME_LIM : v[TIME_W-1:0];
  endfunction

  // Terminal pins and fault line are asynchronous to mclk_i
  // levels sampled twice
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      term_meta_r  <= '0;
      term_r       <= '0;
      fault_meta_r <= 1'b0;
      fault_r      <= 1'b0;
      settle_r     <= '0;
    end else begin
      term_meta_r  <= term_i;
      term_r       <= term_meta_r;
      fault_meta_r <= fault_i;
      fault_r      <= fault_meta_r;
      settle_r     <= {settle_r[0], 1'b1};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CNT - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
      tick_r     <= 1'b0;
    end
  end

  // Write address and data may arrive in either order
  assign do_write = aw_got_r & w_got_r & ~bvalid_o;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OK;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_addr_r <= awaddr_i;
        aw_got_r  <= 1'b1;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
        w_got_r  <= 1'b1;
        wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o  <= (aw_addr_r[7:2] <= TARGET_OFFS[7:2] && aw_addr_r[1:0] == 2'h0)
                    ? RESP_OK : RESP_ERR;
      end
      if (bvalid_o && bready_i) begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    logic [31:0] v;
    v = '0;
    if (!nrst_i) begin
      cfg_r.drive_mode            <= MODE_FWD_REV;
      cfg_r.rotation_dir_select   <= 1'b0;
      cfg_r.direction_inhibit     <= '0;
      cfg_r.powerup_autostart     <= 1'b0;
      cfg_r.fault_clear_autostart <= 1'b0;
      cfg_r.input_function        <= {FUNC_RST3, FUNC_RST2, FUNC_RST1, FUNC_RST0};
      cfg_r.main_freq             <= MAIN_RST;
      cfg_r.step_freq_one         <= STEP1_RST;
      cfg_r.step_freq_two         <= STEP2_RST;
      cfg_r.step_freq_three       <= STEP3_RST;
      cfg_r.top_frequency         <= TOP_RST;
      cfg_r.min_start_frequency   <= MINST_RST;
      cfg_r.acc_time              <= ACC_RST;
      cfg_r.dec_time              <= DEC_RST;
    end else if (do_write) begin
      v = merge(rdata_of(aw_addr_r), w_data_r, w_strb_r);
      unique case (aw_addr_r)
        CTRL_OFFS: begin
          cfg_r.drive_mode            <= drive_mode_type'(v[CTRL_MODE_LSB +: 2]);
          cfg_r.rotation_dir_select   <= v[CTRL_DIR_BIT];
          cfg_r.direction_inhibit     <= v[CTRL_INH_LSB +: 2];
          cfg_r.powerup_autostart     <= v[CTRL_PWR_BIT];
          cfg_r.fault_clear_autostart <= v[CTRL_FLT_BIT];
        end
        FUNC_OFFS: begin
          for (int i = 0; i < NUM_INPUTS; i++) begin
            cfg_r.input_function[i] <= v[i*FUNC_STRIDE +: FUNC_W];
          end
        end
        MAIN_OFFS:  cfg_r.main_freq           <= lim_freq(v);
        STEP1_OFFS: cfg_r.step_freq_one       <= lim_freq(v);
        STEP2_OFFS: cfg_r.step_freq_two       <= lim_freq(v);
        STEP3_OFFS: cfg_r.step_freq_three     <= lim_freq(v);
        TOP_OFFS:   cfg_r.top_frequency       <= lim_freq(v);
        MINST_OFFS: cfg_r.min_start_frequency <= lim_freq(v);
        ACC_OFFS:   cfg_r.acc_time            <= lim_time(v);
        DEC_OFFS:   cfg_r.dec_time            <= lim_time(v);
        default: begin
        end
      endcase
    end
  end

  // Key register is write-only; each written one is a single key press
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      key_run_r  <= 1'b0;
      key_stop_r <= 1'b0;
    end else begin
      key_run_r  <= do_write && aw_addr_r == KEY_OFFS && w_strb_r[0] && w_data_r[KEY_RUN_BIT];
      key_stop_r <= do_write && aw_addr_r == KEY_OFFS && w_strb_r[0] && w_data_r[KEY_STOP_BIT];
    end
  end

  function automatic logic [31:0] rdata_of(input logic [7:0] a);
    logic [31:0] d;
    d = '0;
    unique case (a)
      CTRL_OFFS: begin
        d[CTRL_MODE_LSB +: 2] = cfg_r.drive_mode;
        d[CTRL_DIR_BIT]       = cfg_r.rotation_dir_select;
        d[CTRL_INH_LSB +: 2]  = cfg_r.direction_inhibit;
        d[CTRL_PWR_BIT]       = cfg_r.powerup_autostart;
        d[CTRL_FLT_BIT]       = cfg_r.fault_clear_autostart;
      end
      FUNC_OFFS: begin
        for (int i = 0; i < NUM_INPUTS; i++) begin
          d[i*FUNC_STRIDE +: FUNC_W] = cfg_r.input_function[i];
        end
      end
      MAIN_OFFS:   d[FREQ_W-1:0] = cfg_r.main_freq;
      STEP1_OFFS:  d[FREQ_W-1:0] = cfg_r.step_freq_one;
      STEP2_OFFS:  d[FREQ_W-1:0] = cfg_r.step_freq_two;
      STEP3_OFFS:  d[FREQ_W-1:0] = cfg_r.step_freq_three;
      TOP_OFFS:    d[FREQ_W-1:0] = cfg_r.top_frequency;
      MINST_OFFS:  d[FREQ_W-1:0] = cfg_r.min_start_frequency;
      ACC_OFFS:    d[TIME_W-1:0] = cfg_r.acc_time;
      DEC_OFFS:    d[TIME_W-1:0] = cfg_r.dec_time;
      STATUS_OFFS: begin
        d[FREQ_W-1:0] = ramp_freq;
        d[ST_RUN_BIT] = running_o;
        d[ST_REV_BIT] = dir_r;
        d[ST_AT_BIT]  = at_target;
        d[ST_FLT_BIT] = fault_r;
      end
      TARGET_OFFS: d[FREQ_W-1:0] = target;
      default:     d = '0;
    endcase
    return d;
  endfunction

  always_comb begin
    rdata_nxt = rdata_of(araddr_i);
    rd_hit    = (araddr_i[7:2] <= TARGET_OFFS[7:2]) && (araddr_i[1:0] == 2'h0);
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= '0;
      rresp_o   <= RESP_OK;
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rdata_o   <= rdata_nxt;
      rresp_o   <= rd_hit ? RESP_OK : RESP_ERR;
    end else if (rvalid_o && rready_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      kp_run_r <= 1'b0;
    end else if (cfg_r.drive_mode != MODE_KEYPAD || key_stop_r || fault_r) begin
      kp_run_r <= 1'b0;
    end else if (key_run_r) begin
      kp_run_r <= 1'b1;
    end
  end

  always_comb begin
    logic fwd;
    logic rev;
    logic cmd;
    logic blocked;
    fwd = any_func(cfg_r.input_function, term_r, FN_FWD);
    rev = any_func(cfg_r.input_function, term_r, FN_REV);
    cmd = 1'b0;
    blocked = 1'b0;
    cmd_dir = 1'b0;
    unique case (cfg_r.drive_mode)
      MODE_KEYPAD: begin
        cmd     = kp_run_r;
        cmd_dir = cfg_r.rotation_dir_select;
      end
      MODE_FWD_REV: begin
        cmd     = fwd ^ rev;
        cmd_dir = rev;
      end
      MODE_RUN_DIR: begin
        cmd     = fwd;
        cmd_dir = rev;
      end
      MODE_RESERVED: begin
        cmd     = 1'b0;
        cmd_dir = dir_r;
      end
    endcase
    term_cmd = cmd && (cfg_r.drive_mode != MODE_KEYPAD);
    blocked = (cfg_r.direction_inhibit == INH_FWD && !cmd_dir) ||
              (cfg_r.direction_inhibit == INH_REV && cmd_dir);
    run_ok = cmd && !blocked && !fault_r &&
             !(hold_pwr_r && !cfg_r.powerup_autostart && cfg_r.drive_mode != MODE_KEYPAD) &&
             !(hold_flt_r && !cfg_r.fault_clear_autostart && cfg_r.drive_mode != MODE_KEYPAD);
  end

  // A terminal command that is already on must drop once before it may start the motor
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hold_pwr_r <= 1'b1;
      hold_flt_r <= 1'b0;
    end else begin
      // Synchronisers must fill first, or the hold clears on their reset zeros
      if ((settle_r[1] && !term_cmd) || run_ok) begin
        hold_pwr_r <= 1'b0;
      end
      // A run that has resumed ends the hold, so clearing autostart cannot stop it
      if (fault_r) begin
        hold_flt_r <= 1'b1;
      end else if (!term_cmd || run_ok) begin
        hold_flt_r <= 1'b0;
      end
    end
  end

  always_comb begin
    logic [1:0] step;
    step = {any_func(cfg_r.input_function, term_r, FN_STEP_HI),
            any_func(cfg_r.input_function, term_r, FN_STEP_LO)};
    unique case (step)
      2'h0: ref_freq = cfg_r.main_freq;
      2'h1: ref_freq = cfg_r.step_freq_one;
      2'h2: ref_freq = cfg_r.step_freq_two;
      2'h3: ref_freq = cfg_r.step_freq_three;
    endcase
    if (ref_freq > cfg_r.top_frequency) begin
      ref_freq = cfg_r.top_frequency;
    end
    if (ref_freq < cfg_r.min_start_frequency) begin
      ref_freq = '0;
    end
    // Reversal ramps down to zero before the direction flips
    target = (run_ok && cmd_dir == dir_r) ? ref_freq : '0;
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      dir_r      <= 1'b0;
      running_o  <= 1'b0;
      reverse_o  <= 1'b0;
      out_freq_o <= '0;
    end else begin
      if (ramp_freq == '0 && run_ok) begin
        dir_r <= cmd_dir;
      end
      running_o  <= run_ok;
      reverse_o  <= dir_r;
      out_freq_o <= ramp_freq;
    end
  end

  freq_ramp u_ramp (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .tick_i      (tick_r),
    .target_i    (target),
    .top_i       (cfg_r.top_frequency),
    .acc_time_i  (cfg_r.acc_time),
    .dec_time_i  (cfg_r.dec_time),
    .freq_o      (ramp_freq),
    .at_target_o (at_target)
  );

endmodule
`default_nettype wire

// File: tb/drive_run_command_ramp_sva.sv
`timescale 1ns/1ns
`default_nettype none
module drive_run_command_ramp_sva
  import drive_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        nrst_i,
  input wire logic        fault_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic        bvalid_o,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic [31:0] rdata_o,
  input wire logic [15:0] out_freq_o,
  input wire logic        running_o,
  input wire logic        reverse_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  sequence s_b_late;
    !bvalid_o ##1 bvalid_o;
  endsequence
  // Ramp may still carry an old tick just after a stop
  property p_falls;
    !running_o && !$past(running_o, 4) && $changed(out_freq_o) |-> out_freq_o < $past(out_freq_o);
  endproperty
  a_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o |=> s_b_late)
    else $error("write answer off");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o && !arready_o)
    else $error("read answer off");
  a_read_holds: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data moved");
  a_freq_limit: assert property (out_freq_o <= FREQ_LIM)
    else $error("freq above limit");
  a_ramp_paced: assert property ($changed(out_freq_o) |=> $stable(out_freq_o) [*8])
    else $error("ramp off tick");
  a_stop_falls: assert property (p_falls)
    else $error("freq rose while stopped");
  a_dir_at_zero: assert property ($changed(reverse_o) |-> out_freq_o == 16'h0000)
    else $error("turned while moving");
  a_fault_stops: assert property (fault_i [*5] |=> !running_o)
    else $error("ran in fault");
endmodule
`default_nettype wire

// File: tb/switch_bank.sv
`timescale 1ns/1ns
`default_nettype none
module switch_bank (
  input  wire logic       mclk_i,
  input  wire logic [3:0] want_i,
  input  wire logic       trip_i,
  output logic      [3:0] term_o = 4'h0,
  output logic            fault_o = 1'h0
);
  // levels move only after an edge
  always @(posedge mclk_i) begin
    term_o <= want_i;
    fault_o <= trip_i;
  end
endmodule
`default_nettype wire

// File: tb/drive_run_command_ramp_test.sv
`timescale 1ns/1ns
`default_nettype none
module drive_run_command_ramp_test;
  import drive_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_type;
  localparam row_type ROWS [15] = '{'{1'h0, CTRL_OFFS, 32'h0, 32'h1},
    '{1'h0, FUNC_OFFS, 32'h0, 32'h03020100}, '{1'h0, STEP1_OFFS, 32'h0, 32'h3E8},
    '{1'h0, STEP2_OFFS, 32'h0, 32'h7D0}, '{1'h0, STEP3_OFFS, 32'h0, 32'hBB8},
    '{1'h0, TOP_OFFS, 32'h0, 32'h1770}, '{1'h0, ACC_OFFS, 32'h0, 32'h32},
    '{1'h0, DEC_OFFS, 32'h0, 32'h64}, '{1'h1, DEC_OFFS, 32'h11170, 32'hEA60},
    '{1'h1, DEC_OFFS, 32'h1, 32'h1}, '{1'h1, ACC_OFFS, 32'h1, 32'h1},
    '{1'h1, STEP1_OFFS, 32'h9000, 32'h4E20}, '{1'h1, MAIN_OFFS, 32'hBB8, 32'hBB8},
    '{1'h1, FUNC_OFFS, 32'h06050100, 32'h06050100}, '{1'h0, 8'h34, 32'h0, 32'h0}};
  localparam logic [15:0] TGT [4] = '{16'hBB8, 16'h1770, 16'h7D0, 16'hBB8};
  logic mclk_i = 1'h0, nrst_i = 1'h0, fault_i, awvalid_i = 1'h0, wvalid_i = 1'h0;
  logic bready_i = 1'h0, arvalid_i = 1'h0, rready_i = 1'h0, trip = 1'h0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, running_o, reverse_o;
  logic [1:0] bresp_o, rresp_o, resp;
  logic [3:0] term_i, want = 4'h0, wstrb_i = 4'hF;
  logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
  logic [15:0] out_freq_o;
  logic [31:0] wdata_i = 32'h0, rdata_o, d;
  int bad_count = 0, n_checks = 0, tn = 0, n;
  switch_bank i_sw (.mclk_i, .want_i(want), .trip_i(trip), .term_o(term_i), .fault_o(fault_i));
  drive_run_command_ramp #(.TICK_CNT(50)) i_dut (.mclk_i, .nrst_i, .term_i, .fault_i,
    .awaddr_i, .awvalid_i, .awready_o, .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .bresp_o,
    .bvalid_o, .bready_i, .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o,
    .rready_i, .out_freq_o, .running_o, .reverse_o);
  always #2 mclk_i = ~mclk_i;
  task automatic chk(input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    awaddr_i <= a;
    wdata_i <= v;
    awvalid_i <= 1'h1;
    wvalid_i <= 1'h1;
    bready_i <= 1'h1;
    do begin
      @(posedge mclk_i);
      if (awready_o) awvalid_i <= 1'h0;
      if (wready_o) wvalid_i <= 1'h0;
    end while (awvalid_i || wvalid_i);
    do @(posedge mclk_i); while (bvalid_o !== 1'h1);
    resp = bresp_o;
    bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'h1;
    rready_i <= 1'h1;
    do @(posedge mclk_i); while (arready_o !== 1'h1);
    arvalid_i <= 1'h0;
    do @(posedge mclk_i); while (rvalid_o !== 1'h1);
    d = rdata_o;
    resp = rresp_o;
    rready_i <= 1'h0;
  endtask
  task automatic st(input logic [3:0] t, input logic e);
    want <= t;
    repeat (8) @(posedge mclk_i);
    chk(running_o, e);
  endtask
  task automatic wrev(input logic v);
    n = 0;
    while (reverse_o !== v && n < 9000) begin
      @(posedge mclk_i);
      n++;
    end
    chk(reverse_o, v);
  endtask
  task automatic rst;
    nrst_i <= 1'h0;
    repeat (12) @(posedge mclk_i);
    nrst_i <= 1'h1;
  endtask
  task automatic fin;
    tn++;
    $display("test %0d done", tn);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (80000) @(posedge mclk_i);
    bad_count++;
    conclude;
  end
  initial begin
    rst;
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a);
      chk(d, ROWS[i].e);
    end
    chk(resp, RESP_ERR);
    fin;
    n = 0;
    want <= 4'h1;
    while (out_freq_o !== 16'hBB8 && n < 4000) begin
      @(posedge mclk_i);
      n++;
    end
    chk(n > 2400 && n < 2600, 1'h1);
    repeat (200) @(posedge mclk_i);
    chk(out_freq_o, 16'hBB8);
    wr(MAIN_OFFS, 32'h31);
    rd(TARGET_OFFS);
    chk(d, 32'h0);
    wr(MAIN_OFFS, 32'h32);
    rd(TARGET_OFFS);
    chk(d, 32'h32);
    wr(MAIN_OFFS, 32'h1771);
    rd(TARGET_OFFS);
    chk(d, 32'h1770);
    wr(MAIN_OFFS, 32'hBB8);
    chk(resp, RESP_OK);
    wr(8'h32, 32'h0);
    chk(resp, RESP_ERR);
    fin;
    foreach (TGT[k]) begin
      want <= {k[1:0], 2'h1};
      repeat (8) @(posedge mclk_i);
      rd(TARGET_OFFS);
      chk(d, {16'h0, TGT[k]});
    end
    st(4'h3, 1'h0);
    st(4'h0, 1'h0);
    st(4'h2, 1'h1);
    wrev(1'h1);
    wr(CTRL_OFFS, 32'h11);
    st(4'h2, 1'h0);
    st(4'h1, 1'h1);
    wr(CTRL_OFFS, 32'h09);
    st(4'h1, 1'h0);
    wr(CTRL_OFFS, 32'h03);
    st(4'h1, 1'h0);
    wr(CTRL_OFFS, 32'h02);
    st(4'h3, 1'h1);
    wrev(1'h1);
    st(4'h1, 1'h1);
    wrev(1'h0);
    fin;
    wr(CTRL_OFFS, 32'h04);
    wr(KEY_OFFS, 32'h1);
    st(4'h0, 1'h1);
    wrev(1'h1);
    wr(KEY_OFFS, 32'h2);
    st(4'h0, 1'h0);
    fin;
    wr(CTRL_OFFS, 32'h41);
    st(4'h1, 1'h1);
    trip <= 1'h1;
    st(4'h1, 1'h0);
    trip <= 1'h0;
    st(4'h1, 1'h1);
    wr(CTRL_OFFS, 32'h01);
    st(4'h1, 1'h1);
    trip <= 1'h1;
    st(4'h1, 1'h0);
    trip <= 1'h0;
    st(4'h1, 1'h0);
    fin;
    rst;
    st(4'h1, 1'h0);
    wr(CTRL_OFFS, 32'h21);
    st(4'h1, 1'h1);
    fin;
    conclude;
  end
endmodule
bind drive_run_command_ramp drive_run_command_ramp_sva i_sva (.mclk_i, .nrst_i, .fault_i,
  .awvalid_i, .awready_o, .wvalid_i, .wready_o, .bvalid_o, .arvalid_i, .arready_o, .rvalid_o,
  .rready_i, .rdata_o, .out_freq_o, .running_o, .reverse_o);
`default_nettype wire
